// ==== core/htc_regs.sv ====
// Function
// (RQ1) receive width: cold strap, applied warm/wake
// (RQ2) max widths read 1, dword caps zero
// (RQ3) tristate bit powers PHY down in disconnect
// (RQ4) separate upper/lower lane CRC flags
// (RQ5) transmitter-off shuts both halves
// (RQ6) high-half bit shuts upper PHY
// (RQ7) init-complete and link-fail status bits
// (RQ8) flood link on CRC when enabled
// (RQ9) frequency capability from PLL, resets 0x0025
// (RQ10) overflow and protocol error flags
// (RQ11) frequency code applied warm/wake only
// (RQ12) feature capability reads 0x00000002
// (RQ13) stop bit rising enters disconnect
// (RQ14) request bit or access wakes link
// (RQ15) nonstandard interrupt vector index plus code
// (RQ16) write format selects dword or masked
// (RQ17) coherence bit mirrors strap pin
// (RQ18) fixed sequence ID unless conversion
// (RQ19) aging channel priorities from four fields
// (RQ20) sample CTL phases and CAD when enabled
// (RQ21) routing field picks vector stripe
// (RQ22) seven receive credit fields, reset value
// (RQ23) stripe-by-one: vector quarters to lines
// (RQ24) read-only writes ignored, reserved reads zero
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
module htc_regs (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // pins from outside the clock domain
  input  wire logic        link_clk,
  input  wire logic [1:0]  link_ctl,
  input  wire logic [15:0] link_cad,
  input  wire logic        coherence_strap_pin,
  input  wire logic [15:0] pll_freq_cap,
  input  wire logic [2:0]  conn_width,
  input  wire logic        warm_rst_pin,
  // events and status from link logic
  input  wire logic        crc_err_hi,
  input  wire logic        crc_err_lo,
  input  wire logic        overflow_evt,
  input  wire logic        bad_cmd_evt,
  input  wire logic        init_done,
  input  wire logic        link_fail,
  input  wire logic        link_access_req,
  // channel arbitration
  input  wire logic [3:0]  chan_req,
  output logic      [3:0]  chan_grant,
  // interrupt mapping
  input  wire logic        nonstd_valid,
  input  wire logic [2:0]  nonstd_code,
  input  wire logic        vec_valid,
  input  wire logic [7:0]  vec_num,
  output logic             int_vec_valid,
  output logic      [7:0]  int_vec,
  output logic             int_line_valid,
  output logic      [1:0]  int_line,
  // link control outputs
  output logic             link_stop_signal_n,
  output logic             link_req_n,
  output logic             upper_phy_shutdown,
  output logic             lower_phy_shutdown,
  output logic             crc_flood,
  output logic      [2:0]  active_width,
  output logic      [3:0]  active_freq,
  output logic             dword_write_mode,
  output logic             skip_id_conversion,
  output logic      [3:0]  fixed_seq_id,
  output logic      [27:0] rx_credit_init
);
  import htc_pkg::*;

  typedef struct packed {
    logic [2:0]  width_pend;  // software view of receive width
    logic [2:0]  width_act;   // width in force
    logic        tri_en;      // power down PHY in disconnect
    logic        crc_hi;      // upper_half_crc_flag
    logic        crc_lo;      // lower_half_crc_flag
    logic        tx_off;      // both halves off
    logic        tx_off_hi;   // upper half off
    logic [1:0]  stat;        // init complete, link fail
    logic        flood_en;
    logic [15:0] freq_cap;
    logic        ovf;
    logic        proto;
    logic [3:0]  freq_pend;
    logic [3:0]  freq_act;
    logic [7:0]  rev;
    logic        stop_gen;
    logic        req_gen;
    logic [4:0]  idx;
    logic        dword;
    logic        coher;
    logic        nocare;
    logic        skip;
    logic [3:0]  fixid;
    logic [15:0] prio;
    logic        sample_en;
    logic [7:0]  ctl_catch;
    logic [15:0] cad_catch;
    logic [1:0]  spread;
    logic [27:0] credit;
    htc_link_state_type lstate;
    logic        cold_load;   // strap capture pending
    logic        lclk_prev;   // last sampled link clock
    logic [2:0]  phase;       // diagnostic phase counter
    logic        warm_prev;
    logic [31:0] rdata;
    logic        phy_lo;
    logic        phy_hi;
    logic        flood;
    logic        stop_n;
    logic        req_n;
    logic        iv_valid;
    logic [7:0]  iv;
    logic        il_valid;
    logic [1:0]  il;
  } htc_regs_state_type;

  htc_regs_state_type s_q, s_d;

  // synchronised pins
  logic        lclk_s;
  logic [1:0]  ctl_s;
  logic [15:0] cad_s;
  logic        coher_s;
  logic [15:0] cap_s;
  logic [2:0]  width_s;
  logic        warm_s;

  // every outside pin crosses here, nothing reads it earlier
  htc_sync #(
    .W (40)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({link_clk, link_ctl, link_cad, coherence_strap_pin,
                pll_freq_cap, conn_width, warm_rst_pin}),
    .sync_out ({lclk_s, ctl_s, cad_s, coher_s, cap_s, width_s, warm_s})
  );

  // aging arbiter over nop, non-posted, response, posted
  htc_arb #(
    .N (4)
  ) u_arb (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .req       (chan_req),
    .prio_init ({s_q.prio[3:0], s_q.prio[7:4],
                 s_q.prio[11:8], s_q.prio[15:12]}), // RQ19
    .grant     (chan_grant)
  );

  // line for a vector under the chosen spread mode
  function automatic logic [1:0] vec_line(logic [1:0] mode,
                                          logic [7:0] v);
    unique case (mode)
      SPREAD_BY1: vec_line = v[7:6]; // RQ21 RQ23
      SPREAD_BY2: vec_line = {v[7], v[0]}; // RQ21
      SPREAD_BY4: vec_line = v[1:0]; // RQ21
      default:    vec_line = v[7:6];
    endcase
  endfunction

  // readback mux, reserved bits zero
  function automatic logic [31:0] reg_view(logic [7:0] a,
                                           htc_regs_state_type s);
    logic [31:0] r;
    r = '0;
    unique case (a)
      OFS_LINK_CFG: begin
        r[CFG_WIDTH_IN +: 3] = s.width_pend;
        r[CFG_MAX_OUT +: 3]  = MAX_WIDTH; // RQ2
        r[CFG_MAX_IN +: 3]   = MAX_WIDTH; // RQ2
        r[CFG_TRI_EN]        = s.tri_en;
        r[CFG_CRC_HI]        = s.crc_hi;
        r[CFG_CRC_LO]        = s.crc_lo;
        r[CFG_TX_OFF]        = s.tx_off;
        r[CFG_INIT]          = s.stat[1]; // RQ7
        r[CFG_FAIL]          = s.stat[0]; // RQ7
        r[CFG_FLOOD]         = s.flood_en;
        r[CFG_TX_OFF_HI]     = s.tx_off_hi;
      end
      OFS_REV_FREQ: begin
        r[REV_CAP +: 16] = s.freq_cap; // RQ9
        r[REV_OVF]       = s.ovf;
        r[REV_PROTO]     = s.proto;
        r[REV_FREQ +: 4] = s.freq_pend;
        r[7:0]           = s.rev;
      end
      OFS_FEATURE: r = FEATURE_VAL; // RQ12
      OFS_MISC: begin
        r[MISC_STOP]       = s.stop_gen;
        r[MISC_REQ]        = s.req_gen;
        r[MISC_IDX +: 5]   = s.idx;
        r[MISC_DWORD]      = s.dword;
        r[MISC_COHER]      = s.coher;
        r[MISC_NOCARE]     = s.nocare;
        r[MISC_SKIP]       = s.skip;
        r[MISC_FIXID +: 4] = s.fixid;
        r[15:0]            = s.prio;
      end
      OFS_DIAG: begin
        r[DIAG_EN]       = s.sample_en;
        r[DIAG_CTL +: 8] = s.ctl_catch;
        r[DIAG_CAD +: 16] = s.cad_catch;
      end
      OFS_ROUTE:  r[ROUTE_SEL +: 2] = s.spread;
      OFS_CREDIT: r[27:0] = s.credit; // RQ22
      default:    r = '0;
    endcase
    return r;
  endfunction

  // next state of the whole bank
  always_comb begin
    logic wr_cfg, wr_rev, wr_misc, wr_diag, wr_route, wr_cred;
    logic stop_rise, req_rise, apply, lclk_edge;
    wr_cfg    = reg_wr && reg_addr == OFS_LINK_CFG;
    wr_rev    = reg_wr && reg_addr == OFS_REV_FREQ;
    wr_misc   = reg_wr && reg_addr == OFS_MISC;
    wr_diag   = reg_wr && reg_addr == OFS_DIAG;
    wr_route  = reg_wr && reg_addr == OFS_ROUTE;
    wr_cred   = reg_wr && reg_addr == OFS_CREDIT;
    stop_rise = wr_misc && reg_wdata[MISC_STOP] && !s_q.stop_gen;
    req_rise  = wr_misc && reg_wdata[MISC_REQ] && !s_q.req_gen;
    apply     = 1'b0;
    lclk_edge = lclk_s != s_q.lclk_prev;
    s_d       = s_q;

    // writable fields; read-only bits are not touched
    if (wr_cfg) begin // RQ24
      s_d.width_pend = reg_wdata[CFG_WIDTH_IN +: 3];
      s_d.tri_en     = reg_wdata[CFG_TRI_EN];
      s_d.crc_hi     = reg_wdata[CFG_CRC_HI];
      s_d.crc_lo     = reg_wdata[CFG_CRC_LO];
      s_d.tx_off     = reg_wdata[CFG_TX_OFF];
      s_d.flood_en   = reg_wdata[CFG_FLOOD];
      s_d.tx_off_hi  = reg_wdata[CFG_TX_OFF_HI];
    end
    if (wr_rev) begin
      s_d.proto     = reg_wdata[REV_PROTO];
      s_d.freq_pend = reg_wdata[REV_FREQ +: 4];
      s_d.rev       = reg_wdata[7:0];
    end
    if (wr_misc) begin
      s_d.stop_gen = reg_wdata[MISC_STOP];
      s_d.req_gen  = reg_wdata[MISC_REQ];
      s_d.idx      = reg_wdata[MISC_IDX +: 5];
      s_d.dword    = reg_wdata[MISC_DWORD];
      s_d.nocare   = reg_wdata[MISC_NOCARE];
      s_d.skip     = reg_wdata[MISC_SKIP];
      s_d.fixid    = reg_wdata[MISC_FIXID +: 4];
      s_d.prio     = reg_wdata[15:0];
    end
    if (wr_diag) begin
      s_d.sample_en = reg_wdata[DIAG_EN];
      s_d.ctl_catch = reg_wdata[DIAG_CTL +: 8];
      s_d.cad_catch = reg_wdata[DIAG_CAD +: 16];
    end
    if (wr_route) begin
      s_d.spread = reg_wdata[ROUTE_SEL +: 2];
    end
    if (wr_cred) begin
      s_d.credit = reg_wdata[27:0];
    end

    // hardware sets win over a clearing write in the same cycle
    s_d.crc_hi = s_d.crc_hi | crc_err_hi; // RQ4
    s_d.crc_lo = s_d.crc_lo | crc_err_lo; // RQ4
    s_d.ovf    = s_q.ovf | overflow_evt; // RQ10
    s_d.proto  = s_d.proto | bad_cmd_evt; // RQ10
    s_d.stat     = {init_done, link_fail}; // RQ7
    s_d.freq_cap = cap_s; // RQ9
    s_d.coher    = coher_s; // RQ17

    // flood for one cycle per detected error
    s_d.flood = s_q.flood_en && (crc_err_hi || crc_err_lo); // RQ8

    // widest width of this connection, caught after reset release
    if (s_q.cold_load) begin
      s_d.cold_load  = 1'b0;
      s_d.width_pend = width_s; // RQ1
      s_d.width_act  = width_s; // RQ1
    end

    // disconnect sequencing
    unique case (s_q.lstate)
      LS_RUN: begin
        if (stop_rise) begin
          s_d.lstate = LS_DISC; // RQ13
        end
      end
      LS_DISC: begin
        if (req_rise || link_access_req) begin
          s_d.lstate = LS_WAKE; // RQ14
          apply      = 1'b1;
        end
      end
      LS_WAKE: begin
        // hold the request until the peer brings the link up
        if (init_done) begin
          s_d.lstate = LS_RUN;
        end
      end
    endcase

    // a warm reset edge also commits the pending values
    s_d.warm_prev = warm_s;
    if (warm_s && !s_q.warm_prev) begin
      apply = 1'b1;
    end
    if (apply && !s_q.cold_load) begin
      s_d.width_act = s_q.width_pend; // RQ1
      s_d.freq_act  = s_q.freq_pend; // RQ11
    end

    s_d.stop_n = s_d.lstate != LS_DISC; // RQ13
    s_d.req_n  = s_d.lstate != LS_WAKE; // RQ14
    s_d.phy_lo = s_d.tx_off ||
                 (s_d.lstate == LS_DISC && s_d.tri_en); // RQ3 RQ5
    s_d.phy_hi = s_d.phy_lo || s_d.tx_off_hi; // RQ5 RQ6

    // diagnostic capture: CTL on each link clock edge, CAD on rising edges only
    s_d.lclk_prev = lclk_s;
    if (!s_d.sample_en) begin
      s_d.phase = '0;
    end else if (lclk_edge) begin
      // even phases from the first line, odd from the second
      s_d.ctl_catch[s_q.phase] = s_q.phase[0] ? ctl_s[1]
                                              : ctl_s[0]; // RQ20
      s_d.phase = s_q.phase + 3'h1;
      if (lclk_s) begin
        s_d.cad_catch = cad_s; // RQ20
      end
    end

    // interrupt vector build and line routing
    s_d.iv_valid = nonstd_valid && nonstd_code != INT_RSVD; // RQ15
    s_d.iv       = {s_q.idx, nonstd_code}; // RQ15
    s_d.il_valid = vec_valid;
    s_d.il       = vec_line(s_q.spread, vec_num);

    // read data only in the cycle after the strobe
    s_d.rdata = reg_rd ? reg_view(reg_addr, s_q) : '0;
  end

  // one register for the whole bank
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q           <= '0;
      s_q.width_pend <= WIDTH_RST;
      s_q.width_act <= WIDTH_RST;
      s_q.tri_en    <= TRI_EN_RST; // RQ3
      s_q.freq_cap  <= FREQ_CAP_RST; // RQ9
      s_q.freq_pend <= FREQ_RST;
      s_q.freq_act  <= FREQ_RST;
      s_q.rev       <= REVISION_RST;
      s_q.idx       <= MISC_RST[MISC_IDX +: 5];
      s_q.dword     <= MISC_RST[MISC_DWORD]; // RQ16
      s_q.skip      <= MISC_RST[MISC_SKIP]; // RQ18
      s_q.fixid     <= MISC_RST[MISC_FIXID +: 4];
      s_q.prio      <= MISC_RST[15:0];
      s_q.credit    <= CREDIT_RST; // RQ22
      s_q.lstate    <= LS_RUN;
      s_q.cold_load <= 1'b1;
      s_q.stop_n    <= 1'b1;
      s_q.req_n     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the bank
  assign reg_rdata          = s_q.rdata;
  assign link_stop_signal_n = s_q.stop_n;
  assign link_req_n         = s_q.req_n;
  assign upper_phy_shutdown = s_q.phy_hi;
  assign lower_phy_shutdown = s_q.phy_lo;
  assign crc_flood          = s_q.flood;
  assign active_width       = s_q.width_act;
  assign active_freq        = s_q.freq_act;
  assign dword_write_mode   = s_q.dword; // RQ16
  assign skip_id_conversion = s_q.skip; // RQ18
  assign fixed_seq_id       = s_q.fixid; // RQ18
  assign rx_credit_init     = s_q.credit;
  assign int_vec_valid      = s_q.iv_valid;
  assign int_vec            = s_q.iv;
  assign int_line_valid     = s_q.il_valid;
  assign int_line           = s_q.il;

  // software raises the stop bit from zero
  sequence s_stop_rise;
    reg_wr && reg_addr == OFS_MISC && reg_wdata[MISC_STOP] &&
      !s_q.stop_gen && s_q.lstate == LS_RUN;
  endsequence

  property p_width_hold;
    @(posedge core_clk) disable iff (sys_rst)
      $changed(active_width) |-> $past(s_q.cold_load) ||
        $past(s_q.lstate) == LS_DISC || $past(warm_s) && !$past(s_q.warm_prev);
  endproperty
  a_width_hold: assert property (p_width_hold) // RQ1
    else $error("active width changed without commit");

  property p_max_width;
    @(posedge core_clk) disable iff (sys_rst)
      reg_rd && reg_addr == OFS_LINK_CFG |=>
        reg_rdata[23:16] == 8'h11;
  endproperty
  a_max_width: assert property (p_max_width) // RQ2
    else $error("maximum width fields wrong");

  property p_disc_power;
    @(posedge core_clk) disable iff (sys_rst)
      s_stop_rise ##1 s_q.tri_en && !s_q.tx_off |->
        !link_stop_signal_n && lower_phy_shutdown && upper_phy_shutdown;
  endproperty
  a_disc_power: assert property (p_disc_power) // RQ3
    else $error("PHY not powered down in disconnect");

  property p_crc_flag;
    @(posedge core_clk) disable iff (sys_rst)
      crc_err_hi |=> s_q.crc_hi;
  endproperty
  a_crc_flag: assert property (p_crc_flag) // RQ4
    else $error("upper crc flag lost");

  property p_tx_off;
    @(posedge core_clk) disable iff (sys_rst)
      s_q.tx_off |-> lower_phy_shutdown && upper_phy_shutdown;
  endproperty
  a_tx_off: assert property (p_tx_off) // RQ5
    else $error("transmitter off not applied");

  property p_flood;
    @(posedge core_clk) disable iff (sys_rst)
      (crc_err_lo || crc_err_hi) |=> crc_flood == $past(s_q.flood_en);
  endproperty
  a_flood: assert property (p_flood) // RQ8
    else $error("flood does not follow enable");

  property p_feature;
    @(posedge core_clk) disable iff (sys_rst)
      reg_rd && reg_addr == OFS_FEATURE |=> reg_rdata == FEATURE_VAL;
  endproperty
  a_feature: assert property (p_feature) // RQ12
    else $error("feature capability wrong");

  property p_disc_entry;
    @(posedge core_clk) disable iff (sys_rst)
      s_stop_rise |-> ##1 !link_stop_signal_n [*2];
  endproperty
  a_disc_entry: assert property (p_disc_entry) // RQ13
    else $error("disconnect not entered");

  property p_wake;
    @(posedge core_clk) disable iff (sys_rst)
      s_q.lstate == LS_DISC && link_access_req |=> !link_req_n;
  endproperty
  a_wake: assert property (p_wake) // RQ14
    else $error("access did not wake link");

  property p_stripe1;
    @(posedge core_clk) disable iff (sys_rst)
      vec_valid && s_q.spread == SPREAD_BY1 |=>
        int_line == $past(vec_num[7:6]) && int_line_valid;
  endproperty
  a_stripe1: assert property (p_stripe1) // RQ23
    else $error("stripe-by-one line wrong");
endmodule

// ==== core/htc_pkg.sv ====
package htc_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_LINK_CFG = 8'h44;
  localparam logic [7:0] OFS_REV_FREQ = 8'h48;
  localparam logic [7:0] OFS_FEATURE  = 8'h4C;
  localparam logic [7:0] OFS_MISC     = 8'h50;
  localparam logic [7:0] OFS_DIAG     = 8'h54;
  localparam logic [7:0] OFS_ROUTE    = 8'h58;
  localparam logic [7:0] OFS_CREDIT   = 8'h5C;

  // reset and fixed values
  localparam logic [31:0] FEATURE_VAL  = 32'h00000002;
  localparam logic [31:0] MISC_RST     = 32'h00904321;
  localparam logic [27:0] CREDIT_RST   = 28'h7778888;
  localparam logic [15:0] FREQ_CAP_RST = 16'h0025;
  localparam logic [2:0]  MAX_WIDTH    = 3'h1;
  localparam logic [2:0]  WIDTH_RST    = 3'h0;
  localparam logic [3:0]  FREQ_RST     = 4'h0;
  localparam logic        TRI_EN_RST   = 1'b1;
  // revision value is arbitrary
  localparam logic [7:0]  REVISION_RST = 8'h5A;

  // link configuration fields
  localparam int CFG_WIDTH_IN = 24;
  localparam int CFG_MAX_OUT  = 20;
  localparam int CFG_MAX_IN   = 16;
  localparam int CFG_TRI_EN   = 13;
  localparam int CFG_CRC_HI   = 9;
  localparam int CFG_CRC_LO   = 8;
  localparam int CFG_TX_OFF   = 7;
  localparam int CFG_INIT     = 5;
  localparam int CFG_FAIL     = 4;
  localparam int CFG_FLOOD    = 1;
  localparam int CFG_TX_OFF_HI = 0;

  // revision / frequency fields
  localparam int REV_CAP   = 16;
  localparam int REV_OVF   = 13;
  localparam int REV_PROTO = 12;
  localparam int REV_FREQ  = 8;

  // miscellaneous control fields
  localparam int MISC_STOP   = 30;
  localparam int MISC_REQ    = 29;
  localparam int MISC_IDX    = 24;
  localparam int MISC_DWORD  = 23;
  localparam int MISC_COHER  = 22;
  localparam int MISC_NOCARE = 21;
  localparam int MISC_SKIP   = 20;
  localparam int MISC_FIXID  = 16;

  // diagnostic and routing fields
  localparam int DIAG_EN   = 0;
  localparam int DIAG_CTL  = 8;
  localparam int DIAG_CAD  = 16;
  localparam int ROUTE_SEL = 8;

  // operating frequency codes
  localparam logic [3:0] FREQ_200 = 4'h0;
  localparam logic [3:0] FREQ_400 = 4'h2;
  localparam logic [3:0] FREQ_800 = 4'h5;

  // low vector code that maps to nothing
  localparam logic [2:0] INT_RSVD = 3'h3;

  // interrupt spread modes
  typedef enum logic [1:0] {
    SPREAD_BY1 = 2'h0,
    SPREAD_BY2 = 2'h1,
    SPREAD_BY4 = 2'h2
  } htc_spread_type;

  // disconnect control states
  typedef enum logic [1:0] {
    LS_RUN,
    LS_DISC,
    LS_WAKE
  } htc_link_state_type;

endpackage

// ==== core/htc_sync.sv ====
`timescale 1ns/10ps
module htc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  import htc_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;  // first stage, read only by second
    logic [W-1:0] sync;  // second stage
  } htc_sync_state_type;

  htc_sync_state_type s_q, s_d;

  // shift through two stages
  always_comb begin
    s_d      = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end

  // no reset, pins flow during reset
  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  assign sync_out = s_q.sync;
endmodule

// ==== core/htc_arb.sv ====
`timescale 1ns/10ps
module htc_arb #(
  parameter int N = 4
) (
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           sys_rst,
  // channel requests and initial priorities
  input  wire logic [N-1:0]   req,
  input  wire logic [4*N-1:0] prio_init,
  // one-hot grant, registered
  output logic      [N-1:0]   grant
);
  import htc_pkg::*;

  typedef struct packed {
    logic [N-1:0][3:0] prio;   // running priority, 0 is best
    logic [N-1:0]      grant;  // current grant
  } htc_arb_state_type;

  htc_arb_state_type s_q, s_d;

  // pick the best waiting channel, age the losers
  always_comb begin
    logic [3:0] best;
    logic       found;
    int         win;
    best  = '1;
    found = 1'b0;
    win   = 0;
    s_d   = s_q;
    for (int i = 0; i < N; i++) begin
      // ties go to the lower index
      if (req[i] && (!found || s_q.prio[i] < best)) begin
        best  = s_q.prio[i];
        found = 1'b1;
        win   = i;
      end
    end
    s_d.grant = '0;
    for (int i = 0; i < N; i++) begin
      if (found && i == win) begin
        // served channel falls back to its initial level
        s_d.grant[i] = 1'b1;
        s_d.prio[i]  = prio_init[4*i +: 4];
      end else if (req[i] && s_q.prio[i] != '0) begin
        // waiting raises priority so nobody starves
        s_d.prio[i] = s_q.prio[i] - 4'h1; // RQ19
      end else if (!req[i]) begin
        s_d.prio[i] = prio_init[4*i +: 4]; // RQ19
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign grant = s_q.grant;
endmodule

// ==== sim/htc_peer.sv ====
`timescale 1ns/10ps
module htc_peer (
  // frame control
  input  wire logic        frame,
  input  wire logic [15:0] cad_val,
  // link pins
  output logic             link_clk,
  output logic      [1:0]  link_ctl,
  output logic      [15:0] link_cad
);
  logic act;
  // hold data a core cycle past the last edge, then show the inverse
  assign #20 act = frame | link_clk;
  assign link_cad = act ? cad_val : ~cad_val;
  assign link_ctl = act ? 2'h3 : 2'h0;
  // clock stands low between frames, phase offset from the core clock
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = frame ? ~link_clk : 1'b0;
  end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  import htc_pkg::*;
  // driven inputs
  logic        core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, frame = 0;
  logic        crc_err_hi = 0, crc_err_lo = 0, overflow_evt = 0;
  logic        bad_cmd_evt = 0, init_done = 0, nonstd_valid = 0;
  logic        vec_valid = 0, link_access_req = 0;
  logic [7:0]  reg_addr = 0, vec_num = 0, v;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [3:0]  chan_req = 0, chan_grant, af;
  logic [2:0]  nonstd_code = 0;
  logic [15:0] cad_val = 0, lf = 16'd13252, link_cad;
  // observed outputs
  logic [27:0] rx_credit_init;
  logic [7:0]  int_vec;
  logic [1:0]  int_line, link_ctl;
  logic        link_clk, int_vec_valid, int_line_valid, link_stop_signal_n;
  logic        link_req_n, upper_phy_shutdown, lower_phy_shutdown;
  logic        crc_flood, dword_write_mode, skip_id_conversion;
  int          errors = 0, n_compared = 0;
  htc_peer peer (.frame, .cad_val, .link_clk, .link_ctl, .link_cad);
  htc_regs DUT (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .link_clk, .link_ctl, .link_cad,
    .coherence_strap_pin(1'b1), .pll_freq_cap(16'h0025),
    .conn_width(3'h1), .warm_rst_pin(1'b0), .crc_err_hi, .crc_err_lo,
    .overflow_evt, .bad_cmd_evt, .init_done, .link_fail(1'b0),
    .link_access_req, .chan_req, .chan_grant, .nonstd_valid,
    .nonstd_code, .vec_valid, .vec_num, .int_vec_valid, .int_vec,
    .int_line_valid, .int_line, .link_stop_signal_n, .link_req_n,
    .upper_phy_shutdown, .lower_phy_shutdown, .crc_flood,
    .active_width(), .active_freq(af), .dword_write_mode,
    .skip_id_conversion, .fixed_seq_id(), .rx_credit_init);
  always #10 core_clk = ~core_clk;
  // random source, feedback taps 16/14/13/11
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // link config word: width 1, max widths 1, tristate on
  function automatic logic [31:0] cfg(logic [1:0] c, logic i, logic f);
    return 32'h01112000 | {c, 8'h0} | {i, 5'h0} | {f, 1'b0};
  endfunction
  // interrupt line for each spread mode, mode 3 acts as by-one
  function automatic logic [1:0] ln(logic [1:0] m, logic [7:0] x);
    return m == 2'h1 ? {x[7], x[0]} : m == 2'h2 ? x[1:0] : x[7:6];
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // bus cycles start right after a rising edge
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk("rdata", e, reg_rdata);
    @(posedge core_clk);
  endtask
  // stop, request and both phy halves, checked mid cycle
  task automatic pins(logic [3:0] e);
    @(negedge core_clk);
    chk("pins", e, {link_stop_signal_n, link_req_n, upper_phy_shutdown,
                    lower_phy_shutdown});
    @(posedge core_clk);
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd(OFS_LINK_CFG, cfg(2'h0, 1'b0, 1'b0));
    rd(OFS_FEATURE, 32'h2);
    rd(OFS_MISC, 32'h00D04321);
    rd(OFS_CREDIT, 32'h07778888);
    rd(OFS_REV_FREQ, {16'h0025, 8'h0, REVISION_RST});
    rd(8'h00, 32'h0);
    wr(OFS_FEATURE, {lf, lf});
    rd(OFS_FEATURE, 32'h2);
    chk("mode", 32'h3, {dword_write_mode, skip_id_conversion});
    $display("reset test done");
    wr(OFS_LINK_CFG, cfg(2'h0, 1'b0, 1'b1));
    {crc_err_hi, crc_err_lo, overflow_evt, bad_cmd_evt, init_done} <= '1;
    @(posedge core_clk);
    {crc_err_hi, crc_err_lo, overflow_evt, bad_cmd_evt} <= 4'h0;
    @(negedge core_clk);
    chk("flood", 32'h1, crc_flood);
    @(posedge core_clk);
    rd(OFS_LINK_CFG, cfg(2'h3, 1'b1, 1'b1));
    rd(OFS_REV_FREQ, {16'h0025, 8'h30, REVISION_RST});
    init_done <= 1'b0;
    $display("event test done");
    lf = nxt(lf);
    wr(OFS_MISC, MISC_RST | {lf[4:0], 24'h0});
    for (int c = 0; c < 8; c++) begin
      nonstd_valid <= 1'b1;
      nonstd_code <= c[2:0];
      @(posedge core_clk);
      nonstd_valid <= 1'b0;
      @(negedge core_clk);
      if (c == 3)
        chk("ivalid", 32'h0, int_vec_valid);
      else
        chk("ivec", {1'b1, lf[4:0], c[2:0]}, {int_vec_valid, int_vec});
      @(posedge core_clk);
    end
    for (int m = 0; m < 4; m++) begin
      wr(OFS_ROUTE, {22'h0, m[1:0], 8'h0});
      for (int i = 0; i < 4; i++) begin
        lf = nxt(lf);
        v = i == 0 ? 8'd127 + m[7:0] : lf[7:0];
        vec_valid <= 1'b1;
        vec_num <= v;
        @(posedge core_clk);
        vec_valid <= 1'b0;
        @(negedge core_clk);
        chk("line", {1'b1, ln(m[1:0], v)}, {int_line_valid, int_line});
        @(posedge core_clk);
      end
    end
    chan_req <= 4'hF;
    @(posedge core_clk);
    chan_req <= 4'h0;
    @(negedge core_clk);
    chk("grant", 32'h8, chan_grant);
    @(posedge core_clk);
    $display("interrupt and arbiter test done");
    wr(OFS_DIAG, 32'h1);
    lf = nxt(lf);
    cad_val <= lf;
    frame <= 1'b1;
    repeat (48) @(posedge core_clk);
    frame <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd(OFS_DIAG, {lf, 16'hFF01});
    wr(OFS_LINK_CFG, 32'h2080);
    pins(4'hF);
    wr(OFS_LINK_CFG, 32'h2001);
    pins(4'hE);
    wr(OFS_LINK_CFG, 32'h2000);
    pins(4'hC);
    wr(OFS_REV_FREQ, {20'h0, FREQ_800, 8'h0});
    wr(OFS_MISC, MISC_RST | 32'h40000000);
    pins(4'h7);
    wr(OFS_MISC, MISC_RST);
    wr(OFS_MISC, MISC_RST | 32'h20000000);
    pins(4'h8);
    chk("freq", FREQ_800, af);
    init_done <= 1'b1;
    repeat (2) @(posedge core_clk);
    pins(4'hC);
    wr(OFS_LINK_CFG, 32'h0);
    wr(OFS_MISC, MISC_RST | 32'h40000000);
    pins(4'h4);
    link_access_req <= 1'b1;
    @(posedge core_clk);
    link_access_req <= 1'b0;
    pins(4'h8);
    $display("link test done");
    summarize();
  end
endmodule
